// ===== rtl/reset_controller.sv
// Purpose: sorts resets by target and source, starts pll lock, latches boot straps
// Assumes: ref_clk at 10 MHz, rst_b is the power-on reset
// Notes: hw_reset_n_pin reaches the sequencer only through the two-flop synchroniser
`timescale 1ns/1ps

// Summary of operation
// - system reset clears all but this controller
// - hardware reset clears everything, history lost except hw_reset_seen, which it sets
// - core reset blocks bus access, core only
// - system reset from software and four units
// - hardware reset while pin held low
// - system or hardware reset holds registers default, units idle
// - boot core ready after system reset ends
// - sample boot straps on power-on, hardware reset release, software reset
// - pin release starts pll locking
module reset_controller
  import reset_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // board pins
  input wire logic hw_reset_n_pin,
  input wire logic [2:0] boot_mode_pins,
  // reset requests from software and other units (level, async)
  input wire logic sw_sys_reset_req,
  input wire logic power_unit_req,
  input wire logic event_ctrl_req,
  input wire logic trigger_unit_req,
  input wire logic emulator_req,
  input wire logic core_reset_req,
  // pll handshake
  input wire logic pll_locked,
  output logic pll_lock_start,
  // reset outputs
  output logic sys_reset_n,
  output logic core_reset_n,
  output logic core_bus_block,
  output logic units_idle,
  output logic boot_core_ready,
  // status kept across system reset
  output logic [2:0] boot_mode_cfg,
  output logic [4:0] last_sys_source,
  output logic hw_reset_seen
);
  // ------------------------------------------------------------
  // request synchronisation
  // ------------------------------------------------------------
  reset_req_if req ();
  logic core_req_s1;
  logic core_req_s2;
  logic hw_rst_q;
  logic pll_s1;
  logic pll_s2;

  reset_req_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .hw_reset_n_pin(hw_reset_n_pin),
    .sys_req_raw({emulator_req, trigger_unit_req, event_ctrl_req, power_unit_req,
                  sw_sys_reset_req}),
    .req(req)
  );

  // core reset request synchroniser
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_req_s1 <= 1'b0;
      core_req_s2 <= 1'b0;
    end else begin
      core_req_s1 <= core_reset_req;
      core_req_s2 <= core_req_s1;
    end
  end

  // pll lock flag synchroniser, the pll answers from its own clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pll_s1 <= 1'b0;
      pll_s2 <= 1'b0;
    end else begin
      pll_s1 <= pll_locked;
      pll_s2 <= pll_s1;
    end
  end

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire hw_active = !req.hw_rst_sync_n;
  wire any_sys_req = |req.sys_req;
  wire hw_release = hw_rst_q && req.hw_rst_sync_n;
  // bit 0 of the request vector is the software source
  wire sw_source = req.sys_req[0];

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic [3:0] hold_cnt;
  logic [3:0] next_hold_cnt;
  logic boot_sample;

  // hold_cnt restarts on every request seen in st_sys_reset, so a source
  // that keeps asserting keeps the system in reset; a low pin overrides all
  // states because a hardware reset must also clear this controller
  // next-state decode
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      st_hw_reset: begin
        if (hw_release) begin
          next_state = st_pll_lock;
        end
      end
      st_pll_lock: begin
        if (pll_s2) begin
          next_state = st_sys_reset;
          next_hold_cnt = sys_hold_init;
        end
      end
      st_sys_reset: begin
        if (any_sys_req) begin
          next_hold_cnt = sys_hold_init;
        end else if (hold_cnt != 4'h0) begin
          next_hold_cnt = hold_cnt - 4'h1;
        end else begin
          next_state = st_run;
        end
      end
      st_run: begin
        if (any_sys_req) begin
          next_state = st_sys_reset;
          next_hold_cnt = sys_hold_init;
        end
      end
      default: begin
        next_state = st_hw_reset;
      end
    endcase
    if (hw_active) begin
      next_state = st_hw_reset;
    end
  end

  // state registers, hardware reset wipes everything
  // hw_rst_q keeps the pin level of the last cycle so its release can be found
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= st_hw_reset;
      hold_cnt <= 4'h0;
      hw_rst_q <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      hw_rst_q <= hw_active;
    end
  end

  // strap sampling moments: release of a power-on or pin hardware reset, and software system reset
  assign boot_sample = (state == st_hw_reset && hw_release)
                       || (state != st_hw_reset && sw_source);

  // ------------------------------------------------------------
  // controller history, survives system reset
  // ------------------------------------------------------------
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_s1 <= boot_rst_value;
      strap_s2 <= boot_rst_value;
      boot_mode_cfg <= boot_rst_value;
      last_sys_source <= src_rst_value;
      hw_reset_seen <= 1'b0;
    end else begin
      strap_s1 <= boot_mode_pins;
      strap_s2 <= strap_s1;
      // the pin level wins over any request seen in the same cycle
      if (hw_active) begin
        boot_mode_cfg <= boot_rst_value;
        last_sys_source <= src_rst_value;
        hw_reset_seen <= 1'b1;
      end else begin
        if (boot_sample) begin
          boot_mode_cfg <= strap_s2;
        end
        if (any_sys_req) begin
          last_sys_source <= req.sys_req;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // reset outputs
  // ------------------------------------------------------------
  // outputs follow next_state so they change on the same edge as the state
  // register; a core-only reset is honoured only while the system runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sys_reset_n <= 1'b0;
      core_reset_n <= 1'b0;
      core_bus_block <= 1'b1;
      units_idle <= 1'b1;
      boot_core_ready <= 1'b0;
      pll_lock_start <= 1'b0;
    end else begin
      sys_reset_n <= (next_state == st_run);
      units_idle <= (next_state != st_run);
      core_reset_n <= (next_state == st_run) && !core_req_s2;
      core_bus_block <= (next_state != st_run) || core_req_s2;
      boot_core_ready <= (next_state == st_run);
      pll_lock_start <= (state == st_hw_reset) && hw_release;
    end
  end
endmodule

// ===== rtl/reset_ctrl_pkg.sv
// Purpose: constants and types shared by the reset controller files
// Assumes: one 10 MHz reference clock
// Notes: boot encodings follow the strap table
package reset_ctrl_pkg;
  localparam int unsigned clk_period_ns = 100;
  localparam int unsigned sync_stages = 2;
  // nanoseconds the system reset pulse is held once requested
  localparam int unsigned sys_hold_ns = 800;
  localparam int unsigned sys_hold_cycles = (sys_hold_ns + clk_period_ns - 1) / clk_period_ns;
  localparam logic [3:0] sys_hold_init = 4'(sys_hold_cycles);
  // boot mode field
  localparam int unsigned boot_mode_width = 3;
  localparam logic [2:0] boot_rst_value = 3'h0;
  localparam logic [2:0] boot_none = 3'h0;
  localparam logic [2:0] boot_serial_flash = 3'h1;
  localparam logic [2:0] boot_serial_host = 3'h2;
  localparam logic [2:0] boot_uart_host = 3'h3;
  localparam logic [2:0] boot_link_host = 3'h4;
  localparam logic [2:0] boot_octal_flash = 3'h5;
  localparam logic [2:0] boot_card = 3'h6;
  // number of system reset sources: sw, power, event, trigger, emulator
  localparam int unsigned n_sys_src = 5;
  localparam logic [4:0] src_rst_value = 5'h00;
  typedef enum logic [2:0] {st_hw_reset, st_pll_lock, st_sys_reset, st_run} seq_state_t;
endpackage

// ===== rtl/reset_req_if.sv
// Purpose: carries synchronised reset requests into the sequencer
// Assumes: all members on ref_clk
// Notes: produced by the synchroniser module
`timescale 1ns/1ps
interface reset_req_if;
  logic hw_rst_sync_n;
  logic [4:0] sys_req;
  modport src (output hw_rst_sync_n, output sys_req);
  modport dst (input hw_rst_sync_n, input sys_req);
endinterface

// ===== rtl/reset_req_sync.sv
// Purpose: two-flop synchronisers for the reset pin and reset requests
// Assumes: inputs may be asynchronous to ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module reset_req_sync
  import reset_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // raw inputs
  input wire logic hw_reset_n_pin,
  input wire logic [4:0] sys_req_raw,
  // synchronised outputs
  reset_req_if.src req
);
  // ------------------------------------------------------------
  // synchroniser chains
  // ------------------------------------------------------------
  logic [5:0] stage1;
  logic [5:0] stage2;

  // two flops per bit; the cleared state reads as the pin held low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= 6'h00;
      stage2 <= 6'h00;
    end else begin
      stage1 <= {hw_reset_n_pin, sys_req_raw};
      stage2 <= stage1;
    end
  end

  assign req.hw_rst_sync_n = stage2[5];
  assign req.sys_req = stage2[4:0];
endmodule

// ===== test/reset_controller_monitor.sv
// Purpose: port checks of reset_controller
// Assumes: one clock, rst_b async active low
// Notes: bound into every reset_controller
`timescale 1ns/1ps
module reset_controller_monitor
  import reset_ctrl_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // watched ports
  input wire logic hw_reset_n_pin,
  input wire logic sw_sys_reset_req,
  input wire logic pll_lock_start,
  input wire logic sys_reset_n,
  input wire logic core_reset_n,
  input wire logic core_bus_block,
  input wire logic units_idle,
  input wire logic boot_core_ready,
  input wire logic hw_reset_seen,
  input wire logic [2:0] boot_mode_cfg,
  input wire logic [4:0] last_sys_source
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  property p_pin; !hw_reset_n_pin [*5] |-> !sys_reset_n && units_idle; endproperty
  a_pin: assert property (p_pin) else $error("pin low, no reset");
  property p_seen; !hw_reset_n_pin [*5] |-> hw_reset_seen; endproperty
  a_seen: assert property (p_seen) else $error("hw reset not logged");
  property p_clear;
    !hw_reset_n_pin [*5] |-> boot_mode_cfg == boot_rst_value
      && last_sys_source == src_rst_value;
  endproperty
  a_clear: assert property (p_clear) else $error("history kept over pin reset");
  property p_keep; hw_reset_seen |=> hw_reset_seen; endproperty
  a_keep: assert property (p_keep) else $error("history lost");
  property p_pll; $rose(hw_reset_n_pin) |-> ##[1:4] pll_lock_start; endproperty
  a_pll: assert property (p_pll) else $error("no pll start");
  property p_pulse; pll_lock_start |=> !pll_lock_start; endproperty
  a_pulse: assert property (p_pulse) else $error("pll start too long");
  property p_boot; $rose(sys_reset_n) |-> boot_core_ready && !units_idle; endproperty
  a_boot: assert property (p_boot) else $error("boot core not ready");
  property p_idle; !sys_reset_n |-> units_idle && !boot_core_ready; endproperty
  a_idle: assert property (p_idle) else $error("units busy in reset");
  property p_core; !core_reset_n |-> core_bus_block; endproperty
  a_core: assert property (p_core) else $error("core open to bus");
  property p_sw; sys_reset_n && $rose(sw_sys_reset_req) |-> ##[1:4] !sys_reset_n; endproperty
  a_sw: assert property (p_sw) else $error("sw reset ignored");
  c_pll: cover property (pll_lock_start);
  c_core: cover property ($fell(core_reset_n) && sys_reset_n);
  c_run: cover property ($rose(sys_reset_n));
endmodule
bind reset_controller reset_controller_monitor u_mon (.ref_clk, .rst_b, .hw_reset_n_pin,
  .sw_sys_reset_req, .pll_lock_start, .sys_reset_n, .core_reset_n, .core_bus_block,
  .units_idle, .boot_core_ready, .hw_reset_seen, .boot_mode_cfg, .last_sys_source);

// ===== test/board_supervisor.sv
// Purpose: board supervisor driving the reset pin
// Assumes: rails_ok means supplies and both clocks valid
// Notes: pin is push-pull
`timescale 1ns/1ps
module board_supervisor (
  // clock
  input wire logic ref_clk,
  // board status
  input wire logic rails_ok,
  input wire logic hold_low,
  // pin
  output logic hw_reset_n_pin
);
  initial hw_reset_n_pin = 1'b0;
  // release only once rails are valid, pull low to assert
  always @(posedge ref_clk) begin
    hw_reset_n_pin <= rails_ok && !hold_low;
  end
endmodule

// ===== test/reset_controller_tb_top.sv
// Purpose: self-checking bench of reset_controller
// Assumes: 10 MHz ref_clk
// Notes: requests are levels driven at the rising edge
`timescale 1ns/1ps
module reset_controller_tb_top;
  import reset_ctrl_pkg::*;
  logic ref_clk = 0, rst_b = 0, rails_ok = 0, hold_low = 1, pll_locked = 0, core_req = 0;
  logic pin, go, sys_n, core_n, blk, idle, rdy, seen;
  logic [2:0] straps = 3'h0, cfg, exp_cfg;
  logic [4:0] req = 5'h00, src;
  int n_errors = 0, checked = 0;
  initial forever #50 ref_clk = ~ref_clk;
  board_supervisor u_board (.ref_clk, .rails_ok, .hold_low, .hw_reset_n_pin(pin));
  reset_controller u_dut (.ref_clk, .rst_b, .hw_reset_n_pin(pin), .boot_mode_pins(straps),
    .sw_sys_reset_req(req[0]), .power_unit_req(req[1]), .event_ctrl_req(req[2]),
    .trigger_unit_req(req[3]), .emulator_req(req[4]), .core_reset_req(core_req),
    .pll_locked, .pll_lock_start(go), .sys_reset_n(sys_n), .core_reset_n(core_n),
    .core_bus_block(blk), .units_idle(idle), .boot_core_ready(rdy),
    .boot_mode_cfg(cfg), .last_sys_source(src), .hw_reset_seen(seen));
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // bounded wait, settled after the edge
  task automatic wait_for(ref logic s, input logic v);
    for (int i = 0; i < 40 && s !== v; i++) @(posedge ref_clk) #1;
    chk(s, v, "wait ran out");
    if (s !== v) end_of_test();
  endtask
  // pin reset with one strap code, then the power-up walk
  task automatic t_hw(input logic [2:0] m);
    @(posedge ref_clk);
    hold_low <= 1'b1;
    straps <= m;
    pll_locked <= 1'b0;
    repeat (8) @(posedge ref_clk);
    chk({sys_n, seen, cfg, src}, {2'b01, boot_rst_value, src_rst_value}, "pin reset");
    hold_low <= 1'b0;
    exp_cfg = m;
    wait_for(go, 1'b1);
    @(posedge ref_clk);
    pll_locked <= 1'b1;
    wait_for(rdy, 1'b1);
    chk({sys_n, idle, blk, cfg}, {3'b100, m}, "boot");
    $display("hw boot %0d done", m);
  endtask
  // one system reset source
  task automatic t_sys(input int b);
    @(posedge ref_clk);
    req[b] <= 1'b1;
    straps <= 3'(b + 1);
    if (b == 0) exp_cfg = 3'h1;
    wait_for(sys_n, 1'b0);
    @(posedge ref_clk);
    req[b] <= 1'b0;
    chk({idle, rdy, seen}, 5'h05, "sys reset");
    chk(src, 5'h01 << b, "source");
    wait_for(rdy, 1'b1);
    chk(cfg, exp_cfg, "straps");
    $display("sys source %0d done", b);
  endtask
  // core-only reset, issued with no traffic pending
  task automatic t_core;
    @(posedge ref_clk);
    core_req <= 1'b1;
    wait_for(core_n, 1'b0);
    chk({blk, sys_n}, 5'h03, "core reset");
    @(posedge ref_clk);
    core_req <= 1'b0;
    wait_for(blk, 1'b0);
    $display("core reset done");
  endtask
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
    rails_ok <= 1'b1;
    for (int m = 0; m < 7; m++) t_hw(3'(m));
    for (int b = 0; b < 5; b++) t_sys(b);
    t_core();
    t_hw(3'h5);
    end_of_test();
  end
endmodule
